/* File: rtl/plgb_logic_block.sv */
// Logic block of eight cells with an APB configuration port.
// Assumes fabric pins are asynchronous to clk and sampled twice before use.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps

// Functional notes
// - Each lookup table is a sixteen-by-one table indexed by its four inputs.
// - Eight cells share one clock with polarity choice, one enable, one set/reset.
// - A global reset after configuration clears every cell flip-flop.
// - A per-flop bit picks synchronous or asynchronous set/reset.
// - Asynchronous mode: set/reset high forces the flop at the next clk edge, no fabric clock edge needed.
// - Synchronous mode: set/reset acts only at an active clock edge.
// - Every cell output reaches every cell input and the fabric.
// - Each cell output is its table result or its flop, by configuration.
// - Edge choice, enable used or not, set/reset used or not, all supported.
// - Carry out is the majority of inputs one, two and carry in.
// - Carry in may replace lookup input three by configuration.
// - Block carry in is low, high or from below; carry out goes above.
// - An unused carry output stays high.
module plgb_logic_block
    import plgb_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fabric side
    input wire logic fabric_clock,
    input wire logic fabric_clock_enable,
    input wire logic set_reset_input,
    input wire logic [31:0] fabric_in,
    input wire logic carry_from_below,
    output logic [7:0] fabric_out,
    output logic carry_to_above
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SYNC_W = FAB_IN_W + 4;

    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] meta_nxt;
    logic [SYNC_W-1:0] sync_r;
    logic [SYNC_W-1:0] sync_nxt;
    logic fclk_prev_r;
    logic fclk_prev_nxt;

    always_comb
    begin
        meta_nxt = {fabric_clock, fabric_clock_enable, set_reset_input,
            carry_from_below, fabric_in};
        sync_nxt = meta_r;
        fclk_prev_nxt = sync_r[SYNC_W-1];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
            fclk_prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            fclk_prev_r <= fclk_prev_nxt;
        end
    end

    logic fclk_s;
    logic ce_s;
    logic sr_s;
    logic below_s;
    logic [31:0] fab_s;

    assign fclk_s = sync_r[SYNC_W-1];
    assign ce_s = sync_r[SYNC_W-2];
    assign sr_s = sync_r[SYNC_W-3];
    assign below_s = sync_r[SYNC_W-4];
    assign fab_s = sync_r[FAB_IN_W-1:0];

    // ****************************************
    // Configuration registers and APB slave
    // ****************************************
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] cfg_r [NUM_CELLS];
    logic [31:0] cfg_nxt [NUM_CELLS];
    logic [31:0] route_r [NUM_CELLS];
    logic [31:0] route_nxt [NUM_CELLS];
    logic configured_r;
    logic configured_nxt;
    logic grst_r;
    logic grst_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [7:0] cell_out_r;
    logic [7:0] cell_out_nxt;
    logic carry_up_r;
    logic carry_up_nxt;

    logic setup;
    logic wr;
    logic [2:0] idx;

    always_comb
    begin
        setup = psel && !penable;
        wr = psel && penable && pwrite && pready_r && !pslverr_r;
        idx = paddr[4:2];
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        route_nxt = route_r;
        configured_nxt = configured_r;
        grst_nxt = 1'b0;
        // Answer decided in setup, so access completes in one cycle
        pready_nxt = setup;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        if (setup)
        begin
            prdata_nxt = 32'h00000000;
            if (paddr[1:0] != 2'h0)
            begin
                pslverr_nxt = 1'b1;
            end
            else if (paddr == ADDR_CTRL)
            begin
                prdata_nxt = ctrl_r;
                prdata_nxt[CTRL_DONE_BIT] = configured_r;
            end
            else if (paddr == ADDR_STATUS)
            begin
                prdata_nxt = {23'h000000, carry_up_r, cell_out_r};
                pslverr_nxt = pwrite;
            end
            else if ((paddr & ADDR_BANK_MASK) == ADDR_CELL_CFG_BASE)
            begin
                prdata_nxt = cfg_r[idx];
            end
            else if ((paddr & ADDR_BANK_MASK) == ADDR_ROUTE_BASE)
            begin
                prdata_nxt = route_r[idx];
            end
            else
            begin
                pslverr_nxt = 1'b1;
            end
        end
        if (wr)
        begin
            if (paddr == ADDR_CTRL)
            begin
                ctrl_nxt = pwdata & CTRL_WR_MASK;
                if (pwdata[CTRL_DONE_BIT])
                begin
                    // Configuration complete: clear all flops once
                    configured_nxt = 1'b1;
                    grst_nxt = 1'b1;
                end
            end
            else if ((paddr & ADDR_BANK_MASK) == ADDR_CELL_CFG_BASE)
            begin
                cfg_nxt[idx] = pwdata & CFG_WR_MASK;
            end
            else if ((paddr & ADDR_BANK_MASK) == ADDR_ROUTE_BASE)
            begin
                route_nxt[idx] = pwdata & ROUTE_WR_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= CTRL_RESET;
            for (int i = 0; i < NUM_CELLS; i++)
            begin
                cfg_r[i] <= CFG_RESET;
                route_r[i] <= ROUTE_RESET;
            end
            configured_r <= 1'b0;
            grst_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            route_r <= route_nxt;
            configured_r <= configured_nxt;
            grst_r <= grst_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ****************************************
    // Shared cell controls
    // ****************************************
    logic active_edge;
    logic block_carry_in;

    always_comb
    begin
        // Polarity bit set selects the falling fabric edge
        if (ctrl_r[CTRL_POL_BIT])
        begin
            active_edge = fclk_prev_r && !fclk_s;
        end
        else
        begin
            active_edge = fclk_s && !fclk_prev_r;
        end
        case (ctrl_r[CTRL_CARRY_SEL_LSB +: 2])
            CARRY_SEL_HIGH: block_carry_in = 1'b1;
            CARRY_SEL_BELOW: block_carry_in = below_s;
            default: block_carry_in = 1'b0;
        endcase
    end

    // ****************************************
    // Cells, routing and carry chain
    // ****************************************
    logic [NUM_CELLS:0] carry;
    logic [NUM_CELLS-1:0] lut_out;
    logic [NUM_CELLS-1:0] flop_q;

    assign carry[0] = block_carry_in;

    generate
        for (genvar c = 0; c < NUM_CELLS; c++)
        begin : g_cell
            logic [3:0] lookup_in;

            // Feedback uses registered outputs, so no combinational loops
            always_comb
            begin
                for (int k = 0; k < LUT_INPUTS; k++)
                begin
                    if (route_r[c][k*SEL_W+3])
                    begin
                        lookup_in[k] = fab_s[c*LUT_INPUTS+k];
                    end
                    else
                    begin
                        lookup_in[k] = cell_out_r[route_r[c][k*SEL_W +: 3]];
                    end
                end
            end

            plgb_lut_carry u_lut
            (
                .lut_init(cfg_r[c][CFG_INIT_LSB +: LUT_ENTRIES]),
                .carry_as_three(cfg_r[c][CFG_CARRY_AS_THREE_BIT]),
                .carry_used(cfg_r[c][CFG_CARRY_EN_BIT]),
                .lookup_in(lookup_in),
                .carry_in(carry[c]),
                .lut_out(lut_out[c]),
                .carry_out(carry[c+1])
            );

            plgb_cell_flip_flop u_ff
            (
                .clk(clk),
                .rst_n(rst_n),
                .global_reset(grst_r),
                .active_edge(active_edge),
                .ce_used(ctrl_r[CTRL_CE_BIT]),
                .ce(ce_s),
                .sr_used(ctrl_r[CTRL_SR_BIT]),
                .set_reset_input(sr_s),
                .is_set_type(cfg_r[c][CFG_SET_BIT]),
                .sr_async(cfg_r[c][CFG_ASYNC_BIT]),
                .d(lut_out[c]),
                .q(flop_q[c])
            );
        end
    endgenerate

    // ****************************************
    // Output registers
    // ****************************************
    always_comb
    begin
        for (int c = 0; c < NUM_CELLS; c++)
        begin
            cell_out_nxt[c] = cfg_r[c][CFG_REG_OUT_BIT] ? flop_q[c] : lut_out[c];
        end
        carry_up_nxt = carry[NUM_CELLS];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cell_out_r <= 8'h00;
            carry_up_r <= 1'b0;
        end
        else
        begin
            cell_out_r <= cell_out_nxt;
            carry_up_r <= carry_up_nxt;
        end
    end

    assign fabric_out = cell_out_r;
    assign carry_to_above = carry_up_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

endmodule

/* File: inc/plgb_pkg.sv */
// Constants for the eight-cell logic block: register map, field layout, reset values.
// Assumes a 32-bit APB slave with 12-bit byte addresses and word-aligned registers.
package plgb_pkg;

    // ****************************************
    // Structure
    // ****************************************
    localparam int NUM_CELLS = 8;
    localparam int LUT_INPUTS = 4;
    localparam int LUT_ENTRIES = 16;
    localparam int SEL_W = 4;
    localparam int FAB_IN_W = NUM_CELLS * LUT_INPUTS;
    localparam int ADDR_W = 12;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CELL_CFG_BASE = 12'h020;
    localparam logic [11:0] ADDR_ROUTE_BASE = 12'h040;
    localparam logic [11:0] ADDR_BANK_MASK = 12'hfe0;

    // ****************************************
    // Block control fields
    // ****************************************
    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_CE_BIT = 1;
    localparam int CTRL_SR_BIT = 2;
    localparam int CTRL_CARRY_SEL_LSB = 4;
    localparam int CTRL_DONE_BIT = 8;
    localparam logic [1:0] CARRY_SEL_LOW = 2'h0;
    localparam logic [1:0] CARRY_SEL_HIGH = 2'h1;
    localparam logic [1:0] CARRY_SEL_BELOW = 2'h2;

    // ****************************************
    // Per-cell configuration fields and register write masks
    // ****************************************
    localparam int CFG_INIT_LSB = 0;
    localparam int CFG_REG_OUT_BIT = 16;
    localparam int CFG_SET_BIT = 17;
    localparam int CFG_ASYNC_BIT = 18;
    localparam int CFG_CARRY_AS_THREE_BIT = 19;
    localparam int CFG_CARRY_EN_BIT = 20;
    localparam logic [31:0] CFG_WR_MASK = 32'h001fffff;
    localparam logic [31:0] CTRL_WR_MASK = 32'h00000037;
    localparam logic [31:0] ROUTE_WR_MASK = 32'h0000ffff;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [31:0] ROUTE_RESET = 32'h00000000;

endpackage

/* File: rtl/plgb_lut_carry.sv */
// Four-input lookup table with carry majority logic for one logic cell.
// Purely combinational; inputs come from registered routing in the block.
`timescale 1ns/1ps

module plgb_lut_carry
    import plgb_pkg::*;
(
    // Configuration
    input wire logic [15:0] lut_init,
    input wire logic carry_as_three,
    input wire logic carry_used,
    // Data
    input wire logic [3:0] lookup_in,
    input wire logic carry_in,
    output logic lut_out,
    output logic carry_out
);

    logic [3:0] index;

    always_comb
    begin
        // Incoming carry may stand in for lookup input three
        index = {carry_as_three ? carry_in : lookup_in[3], lookup_in[2:0]};
        lut_out = lut_init[index];
        if (carry_used)
        begin
            carry_out = (lookup_in[1] & lookup_in[2]) | (carry_in & lookup_in[1])
                | (carry_in & lookup_in[2]);
        end
        else
        begin
            carry_out = 1'b1;
        end
    end

endmodule

/* File: rtl/plgb_cell_flip_flop.sv */
// Configurable flip-flop of one logic cell.
// Fabric clock edge, enable and set/reset arrive already synchronised to clk.
`timescale 1ns/1ps

module plgb_cell_flip_flop
    import plgb_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Shared controls
    input wire logic global_reset,
    input wire logic active_edge,
    input wire logic ce_used,
    input wire logic ce,
    input wire logic sr_used,
    input wire logic set_reset_input,
    // Cell configuration
    input wire logic is_set_type,
    input wire logic sr_async,
    // Data
    input wire logic d,
    output logic q
);

    logic q_r;
    logic q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        if (global_reset)
        begin
            q_nxt = 1'b0;
        end
        else if (sr_used && sr_async && set_reset_input)
        begin
            // Acts every cycle, no fabric edge needed
            q_nxt = is_set_type;
        end
        else if (active_edge)
        begin
            if (sr_used && !sr_async && set_reset_input)
            begin
                q_nxt = is_set_type;
            end
            else if (!ce_used || ce)
            begin
                q_nxt = d;
            end
            // Otherwise hold: gated edge with enable low
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_r <= 1'b0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

/* File: tb/plgb_logic_block_sva.sv */
// Checker for the logic block's APB configuration port.
// Sees only top ports; bound into every plgb_logic_block instance.
`timescale 1ns/1ps

module plgb_logic_block_sva
    import plgb_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ****************************************
    // Helpers
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic acc;
    logic unmapped;
    assign acc = psel && penable && pready;
    // Holes between STATUS and the cell bank, and above the route bank
    assign unmapped = (paddr >= 12'h060) || (paddr >= 12'h008 && paddr < 12'h020);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    a_setup_answer: assert property (s_setup |=> s_answer)
        else $error("setup not answered in next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside access cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_misalign_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_unmapped_err: assert property (acc && unmapped |-> pslverr)
        else $error("unmapped access not refused");
    a_status_wr_err: assert property (acc && pwrite && paddr == ADDR_STATUS |-> pslverr)
        else $error("status write not refused");
    a_mapped_ok: assert property (acc && !unmapped && paddr[1:0] == 2'h0
        && !(pwrite && paddr == ADDR_STATUS) |-> !pslverr)
        else $error("legal access refused");
    a_err_read_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
endmodule

bind plgb_logic_block plgb_logic_block_sva i_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

/* File: tb/testbench.sv */
// Self-checking bench: APB setup of the block, then fabric behaviour.
// Assumes zero-wait APB and a few clk of fabric input latency.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module testbench
    import plgb_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic fclk = 1'b0, fce = 1'b0, sr = 1'b0, cfb = 1'b0;
    logic [31:0] fin = 32'h0;
    logic [7:0] fout;
    logic cta;
    logic [31:0] rd;
    logic er;
    int miscompares = 0;
    int tests_run = 0;

    always #2 clk = ~clk;

    plgb_logic_block i_plgb_logic_block (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fabric_clock(fclk), .fabric_clock_enable(fce),
        .set_reset_input(sr), .fabric_in(fin), .carry_from_below(cfb), .fabric_out(fout),
        .carry_to_above(cta));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                miscompares++;
                final_report();
            end
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, rd)
        `CHK("pslverr", ee, er)
    endtask

    task automatic cfg(input int c, input logic [31:0] v);
        apb(1'b1, ADDR_CELL_CFG_BASE + 12'(4 * c), v);
    endtask

    task automatic rt(input int c, input logic [31:0] v);
        apb(1'b1, ADDR_ROUTE_BASE + 12'(4 * c), v);
    endtask

    // Each level held well over two clk so the synchroniser sees it
    task automatic pulse();
        fclk <= ~fclk;
        wt(8);
        fclk <= ~fclk;
        wt(8);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdx(ADDR_CTRL, 32'h0, 1'b0);
        rdx(ADDR_CELL_CFG_BASE, 32'h0, 1'b0);
        rdx(ADDR_STATUS, 32'h100, 1'b0);
        rdx(12'h010, 32'h0, 1'b1);
        rdx(12'h022, 32'h0, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'hff);
        `CHK("status write refused", 1'b1, er)
    endtask

    task automatic t_lut();
        logic [15:0] init;
        init = 16'hb4e1;
        cfg(0, {16'h0, init});
        rt(0, 32'h8888);
        for (int i = 0; i < 16; i++)
        begin
            fin <= 32'(i);
            wt(8);
            `CHK("lut out", init[i], fout[0])
        end
    endtask

    task automatic t_carry();
        logic [9:0] sels;
        logic [4:0] bel;
        logic [4:0] ex;
        sels = 10'b11_10_10_01_00;
        bel = 5'b10101;
        ex = 5'b00110;
        for (int c = 0; c < 8; c++)
        begin
            cfg(c, 32'h00100000);
            rt(c, 32'h8888);
        end
        // Cell 0 shows the block carry in through its table
        cfg(0, 32'h0018ff00);
        fin <= 32'h22222222;
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b1, ADDR_CTRL, {26'h0, sels[2*k +: 2], 4'h0});
            cfb <= bel[k];
            wt(8);
            `CHK("carry chain", ex[k], cta)
            `CHK("carry as input three", ex[k], fout[0])
        end
        apb(1'b1, ADDR_CTRL, 32'h10);
        fin <= 32'h99999999;
        wt(8);
        `CHK("carry kill", 1'b0, cta)
        apb(1'b1, ADDR_CTRL, 32'h0);
        fin <= 32'h66666666;
        wt(8);
        `CHK("carry generate", 1'b1, cta)
        fin <= 32'h99999999;
        cfg(7, 32'h0);
        wt(8);
        `CHK("unused carry", 1'b1, cta)
    endtask

    task automatic t_flop();
        cfg(1, 32'h0001aaaa);
        rt(1, 32'h8888);
        cfg(2, 32'h0000aaaa);
        rt(2, 32'h0001);
        apb(1'b1, ADDR_CTRL, 32'h0);
        fin <= 32'h10;
        pulse();
        `CHK("rise load", 1'b1, fout[1])
        `CHK("feedback", 1'b1, fout[2])
        apb(1'b1, ADDR_CTRL, 32'h1);
        fin <= 32'h0;
        fclk <= 1'b1;
        wt(8);
        `CHK("rise ignored", 1'b1, fout[1])
        fclk <= 1'b0;
        wt(8);
        `CHK("fall load", 1'b0, fout[1])
        apb(1'b1, ADDR_CTRL, 32'h2);
        fin <= 32'h10;
        pulse();
        `CHK("enable low holds", 1'b0, fout[1])
        fce <= 1'b1;
        pulse();
        `CHK("enable high loads", 1'b1, fout[1])
        apb(1'b1, ADDR_CTRL, 32'h6);
        sr <= 1'b1;
        wt(8);
        `CHK("sync waits for edge", 1'b1, fout[1])
        pulse();
        `CHK("sync reset", 1'b0, fout[1])
        sr <= 1'b0;
        cfg(1, 32'h0005aaaa);
        pulse();
        sr <= 1'b1;
        wt(8);
        `CHK("async reset", 1'b0, fout[1])
        sr <= 1'b0;
        cfg(1, 32'h0007aaaa);
        fin <= 32'h0;
        pulse();
        sr <= 1'b1;
        wt(8);
        `CHK("async set", 1'b1, fout[1])
        sr <= 1'b0;
        wt(8);
        `CHK("set kept", 1'b1, fout[1])
        apb(1'b1, ADDR_CTRL, 32'h106);
        wt(4);
        `CHK("global clear", 1'b0, fout[1])
        rdx(ADDR_CTRL, 32'h106, 1'b0);
        cfg(1, 32'h0003aaaa);
        sr <= 1'b1;
        wt(8);
        `CHK("sync set waits for edge", 1'b0, fout[1])
        pulse();
        `CHK("sync set", 1'b1, fout[1])
        sr <= 1'b0;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        final_report();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_lut();
        t_carry();
        t_flop();
        final_report();
    end
endmodule
